// [rtl/ppd_deadtime.sv]
/*
 * Deadtime inserter for one channel pair.
 * Assumes tick is a one-cycle pulse per PWM clock from the prescaler.
 */
`timescale 1ns/1ps
`default_nettype none
module ppd_deadtime
	import ppd_pkg::*;
(
	// Clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// Control
	input  wire logic            tick,
	input  wire logic            comp,
	input  wire logic [DT_W-1:0] dt,
	// Pair in and out
	input  wire logic            in_top,
	input  wire logic            in_bot,
	output logic                 out_top,
	output logic                 out_bot
);
	logic            cur;
	logic            chg;
	logic            gap;
	logic [DT_W-1:0] dcnt;

	// Both sides go off in the very cycle the compare flips, so the gap
	// spans dt whole prescaled ticks; a new edge restarts the gap
	assign chg = comp && in_top != cur;
	assign gap = (chg && dt != '0) || dcnt != '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur  <= 1'b0;
			dcnt <= '0;
		end else if (chg) begin
			cur  <= in_top;
			// The flip cycle already counts when it ends on a tick
			dcnt <= (tick && dt != '0) ? dt - 1'b1 : dt;
		end else if (tick && dcnt != '0) begin
			dcnt <= dcnt - 1'b1;
		end
	end

	assign out_top = comp ? (in_top && !gap) : in_top;
	assign out_bot = comp ? (!in_top && !gap) : in_bot;
endmodule : ppd_deadtime
`default_nettype wire

// [rtl/ppd_pkg.sv]
/*
 * Constants for the PWM pair configuration and deadtime block: register
 * offsets, field positions, reset values and widths.
 * Assumes a 32-bit APB master and one aligned word per register.
 */
package ppd_pkg;
	localparam int NUM_CH   = 6;
	localparam int DT_W     = 12;
	localparam int PRSC_W   = 4;

	// Byte offsets
	localparam logic [7:0] OFS_CFG0   = 8'h00;
	localparam logic [7:0] OFS_CFG1   = 8'h04;
	localparam logic [7:0] OFS_DTMC   = 8'h08;
	localparam logic [7:0] OFS_OUTC   = 8'h0c;
	localparam logic [7:0] OFS_OUTB   = 8'h10;
	localparam logic [7:0] OFS_MASK   = 8'h14;
	localparam logic [7:0] OFS_MOD    = 8'h18;
	localparam logic [7:0] OFS_PRSC   = 8'h1c;
	localparam logic [7:0] OFS_PW0    = 8'h20;
	localparam logic [7:0] OFS_PW_END = 8'h38;
	localparam logic [7:0] OFS_STAT   = 8'h38;

	// Configuration zero fields
	localparam int CFG0_INDEP_A = 0;
	localparam int CFG0_INDEP_B = 1;
	localparam int CFG0_INDEP_C = 2;
	localparam int CFG0_WP      = 7;
	// Configuration one: bits 5..0 are per-channel polarity, 2n top, 2n+1 bottom
	localparam int CFG1_POL_LSB = 0;
	localparam int CFG1_BOT_C   = 5;
	localparam int CFG1_COMMUTATION_ENABLE    = 6;

	localparam logic [DT_W-1:0]   DT_RESET   = 12'hfff;
	localparam logic [PRSC_W-1:0] PRSC_RESET = 4'h0;
	localparam logic [15:0]       MOD_RESET  = 16'h0100;
endpackage : ppd_pkg

// [rtl/ppd_pwm_config.sv]
/*
 * PWM pair configuration with deadtime: APB register file, prescaled
 * counter, compare, complementary/independent pairing, output control
 * with commutation buffering, mask and polarity.
 * Assumes an APB master on pclk and an asynchronous commutation pin.
 */
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ppd_pwm_config
	import ppd_pkg::*;
#(
	parameter int CNT_W = 15
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Commutation event pin
	input  wire logic              commutation_evt,
	// PWM outputs
	output logic [NUM_CH-1:0]      pwm_out
);
	if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt_w
		$error("ppd_pwm_config: CNT_W must be 2 to 16");
	end

	function automatic logic f_hit(input logic [7:0] a);
		f_hit = (a[1:0] == 2'b00) && (a <= OFS_STAT);
	endfunction : f_hit

	function automatic logic [2:0] f_pw_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - OFS_PW0;
		f_pw_idx = d[4:2];
	endfunction : f_pw_idx

	function automatic logic f_pol(input logic v, input logic neg);
		f_pol = neg ? ~v : v;
	endfunction : f_pol

	logic                   wr_en;
	logic                   rd_setup;
	logic [2:0]             indep;
	logic                   wp;
	logic [6:0]             cfg1;
	logic [DT_W-1:0]        dt;
	logic [NUM_CH-1:0]      shd_ctl;
	logic [NUM_CH-1:0]      shd_val;
	logic [NUM_CH-1:0]      shd_mask;
	logic [NUM_CH-1:0]      act_ctl;
	logic [NUM_CH-1:0]      act_val;
	logic [NUM_CH-1:0]      act_mask;
	logic [CNT_W-1:0]       modulus;
	logic [PRSC_W-1:0]      prsc;
	logic [CNT_W-1:0]       pw [NUM_CH];
	logic [PRSC_W-1:0]      pre_cnt;
	logic                   tick;
	logic [CNT_W-1:0]       cnt;
	logic                   cnt_last;
	logic                   comm_sync;
	logic                   comm_q;
	logic                   comm_evt;
	logic                   commutation_enable;
	logic [NUM_CH-1:0]      raw;
	logic [NUM_CH-1:0]      pre;
	logic [NUM_CH-1:0]      next_pwm;

	// APB: zero wait states, read data captured in the setup cycle
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !f_hit(paddr);
	assign wr_en    = psel && penable && pwrite && f_hit(paddr);
	assign rd_setup = psel && !penable && !pwrite;
	assign commutation_enable     = cfg1[CFG1_COMMUTATION_ENABLE];

	// Mode and polarity bits; write protect is set-only until reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			indep <= '0;
			wp    <= 1'b0;
			cfg1  <= '0;
		end else if (wr_en && !wp) begin
			if (paddr == OFS_CFG0) begin
				indep <= {pwdata[CFG0_INDEP_C], pwdata[CFG0_INDEP_B],
					pwdata[CFG0_INDEP_A]};
				wp    <= pwdata[CFG0_WP];
			end
			if (paddr == OFS_CFG1)
				cfg1 <= pwdata[6:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dt <= DT_RESET;
		else if (wr_en && paddr == OFS_DTMC)
			dt <= pwdata[DT_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modulus <= MOD_RESET[CNT_W-1:0];
			prsc    <= PRSC_RESET;
		end else if (wr_en) begin
			if (paddr == OFS_MOD)
				modulus <= pwdata[CNT_W-1:0];
			if (paddr == OFS_PRSC)
				prsc <= pwdata[PRSC_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_CH; i++)
				pw[i] <= '0;
		end else if (wr_en && paddr >= OFS_PW0 && paddr < OFS_PW_END) begin
			pw[f_pw_idx(paddr)] <= pwdata[CNT_W-1:0];
		end
	end

	// Commutation pin: synchronised, rising edge taken from the clean copy
	ppd_sync u_comm_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (commutation_evt),
		.sync_out (comm_sync)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			comm_q <= 1'b0;
		else
			comm_q <= comm_sync;
	end

	assign comm_evt = commutation_enable && comm_sync && !comm_q;

	// Written values land in the shadow set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shd_ctl  <= '0;
			shd_val  <= '0;
			shd_mask <= '0;
		end else if (wr_en) begin
			if (paddr == OFS_OUTC)
				shd_ctl <= pwdata[NUM_CH-1:0];
			if (paddr == OFS_OUTB)
				shd_val <= pwdata[NUM_CH-1:0];
			if (paddr == OFS_MASK)
				shd_mask <= pwdata[NUM_CH-1:0];
		end
	end

	// Active set: follows writes directly, or waits for a commutation edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_ctl  <= '0;
			act_val  <= '0;
			act_mask <= '0;
		end else if (commutation_enable) begin
			if (comm_evt) begin
				act_ctl  <= shd_ctl;
				act_val  <= shd_val;
				act_mask <= shd_mask;
			end
		end else if (wr_en) begin
			if (paddr == OFS_OUTC)
				act_ctl <= pwdata[NUM_CH-1:0];
			if (paddr == OFS_OUTB)
				act_val <= pwdata[NUM_CH-1:0];
			if (paddr == OFS_MASK)
				act_mask <= pwdata[NUM_CH-1:0];
		end
	end

	// Prescaler: a setting of n divides the core clock by n+1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pre_cnt <= '0;
		else if (pre_cnt >= prsc)
			pre_cnt <= '0;
		else
			pre_cnt <= pre_cnt + 1'b1;
	end

	assign tick     = (pre_cnt >= prsc);
	assign cnt_last = (modulus == '0) || (cnt >= modulus - 1'b1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt <= '0;
		else if (tick)
			cnt <= cnt_last ? '0 : cnt + 1'b1;
	end

	// Compare: active level while the counter has not passed the width
	always_comb begin
		for (int i = 0; i < NUM_CH; i++)
			raw[i] = (cnt <= pw[i]);
	end

	// In complementary mode the bottom follows the inverted top
	for (genvar p = 0; p < NUM_CH / 2; p++) begin : g_pair
		ppd_deadtime u_dt (
			.pclk    (pclk),
			.presetn (presetn),
			.tick    (tick),
			.comp    (!indep[p]),
			.dt      (dt),
			.in_top  (raw[2*p]),
			.in_bot  (raw[2*p+1]),
			.out_top (pre[2*p]),
			.out_bot (pre[2*p+1])
		);
	end

	// Polarity last, so a masked channel rests at its inactive level
	always_comb begin
		logic v;
		v = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			v = act_ctl[i] ? act_val[i] : pre[i];
			v = act_mask[i] ? 1'b0 : v;
			next_pwm[i] = f_pol(v, cfg1[CFG1_POL_LSB+i]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pwm_out <= '0;
		else
			pwm_out <= next_pwm;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_setup) begin
			case (paddr)
				OFS_CFG0: prdata <= 32'({wp, 4'h0, indep});
				OFS_CFG1: prdata <= 32'(cfg1);
				OFS_DTMC: prdata <= 32'(dt);
				OFS_OUTC: prdata <= 32'(shd_ctl);
				OFS_OUTB: prdata <= 32'(shd_val);
				OFS_MASK: prdata <= 32'(shd_mask);
				OFS_MOD:  prdata <= 32'(modulus);
				OFS_PRSC: prdata <= 32'(prsc);
				OFS_STAT: prdata <= 32'({act_mask, act_val, act_ctl, pwm_out});
				default: begin
					if (paddr >= OFS_PW0 && paddr < OFS_PW_END &&
						paddr[1:0] == 2'b00)
						prdata <= 32'(pw[f_pw_idx(paddr)]);
					else
						prdata <= '0;
				end
			endcase
		end
	end

	// Checks
	logic out_of_reset;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			out_of_reset <= 1'b0;
		else
			out_of_reset <= 1'b1;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_dt_reset_max: assert property (
		!out_of_reset |-> dt == DT_RESET)
		else $error("deadtime not at maximum after reset");

	a_wp_cfg_lock: assert property (
		wp && psel && penable && pwrite |=> $stable(cfg1) && $stable(indep))
		else $error("configuration changed while write protected");

	a_imm_ctl_apply: assert property (
		!commutation_enable && wr_en && paddr == OFS_OUTC
		|=> act_ctl == $past(pwdata[NUM_CH-1:0]))
		else $error("output control not applied at once");

	a_buf_ctl_hold: assert property (
		commutation_enable && !comm_evt |=> $stable(act_ctl) && $stable(act_mask))
		else $error("buffered output control applied without event");

	a_comm_apply: assert property (
		commutation_enable && comm_evt |=> act_ctl == $past(shd_ctl)
			&& act_mask == $past(shd_mask))
		else $error("commutation event did not apply shadow set");

	a_pos_pol_ch0: assert property (
		indep[0] && !cfg1[0] && !act_ctl[0] && !act_mask[0]
		|=> pwm_out[0] == $past(cnt <= pw[0]))
		else $error("positive polarity output wrong");

	a_neg_pol_ch0: assert property (
		indep[0] && cfg1[0] && !act_ctl[0] && !act_mask[0]
		|=> pwm_out[0] == !$past(cnt <= pw[0]))
		else $error("negative polarity output wrong");

	a_pair_c_bot: assert property (
		indep[2] && !act_ctl[5] && !act_mask[5]
		|=> pwm_out[5] == ($past(cfg1[CFG1_BOT_C]) ^ $past(cnt <= pw[5])))
		else $error("pair C bottom polarity wrong");

	a_comp_b_excl: assert property (
		!indep[1] && cfg1[3:2] == 2'b00 && act_ctl[3:2] == 2'b00
		|=> !(pwm_out[2] && pwm_out[3]))
		else $error("pair B complementary outputs both high");

	a_comp_a_excl: assert property (
		!indep[0] && cfg1[1:0] == 2'b00 && act_ctl[1:0] == 2'b00
		|=> !(pwm_out[0] && pwm_out[1]))
		else $error("pair A complementary outputs both high");

	a_imm_val_apply: assert property (
		!commutation_enable && wr_en && paddr == OFS_OUTB
		|=> act_val == $past(pwdata[NUM_CH-1:0]))
		else $error("output value not applied at once");

	a_imm_mask_apply: assert property (
		!commutation_enable && wr_en && paddr == OFS_MASK
		|=> act_mask == $past(pwdata[NUM_CH-1:0]))
		else $error("mask not applied at once");

	a_dt_write_load: assert property (
		wr_en && paddr == OFS_DTMC |=> dt == $past(pwdata[DT_W-1:0]))
		else $error("deadtime count not loaded");

	c_comm_event: cover property (commutation_enable && comm_evt);
	c_wp_blocked: cover property (wp && wr_en && paddr == OFS_CFG1);
	c_wp_set: cover property ($rose(wp));
	c_comp_gap: cover property (!indep[0] && !pre[0] && !pre[1] ##1 pre[1]);
endmodule : ppd_pwm_config
`default_nettype wire

// [rtl/ppd_sync.sv]
/*
 * Two-flop synchroniser for one level from outside the pclk domain.
 * Assumes the input is a slow level held for at least two pclk cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module ppd_sync
	import ppd_pkg::*;
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Level
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta     <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule : ppd_sync
`default_nettype wire

// [testbench/ppd_commut_src.sv]
/*
 * Far-side model: source of the commutation event pin.
 * Assumes fire is a one-cycle request and hold is at least two.
 */
`timescale 1ns/1ps
`default_nettype none
module ppd_commut_src (
	// Clock
	input  wire logic       pclk,
	// Request
	input  wire logic       fire,
	input  wire logic [3:0] hold,
	// Pin
	output logic            commutation_evt
);
	logic [3:0] cnt = 4'h0;

	// Held high for hold cycles so the synchroniser cannot miss it
	always @(posedge pclk) begin
		if (fire && cnt == 4'h0)
			cnt <= hold;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end
	assign commutation_evt = (cnt != 4'h0);
endmodule : ppd_commut_src
`default_nettype wire

// [testbench/tb.sv]
/*
 * Self-checking bench for the PWM pair configuration block.
 * Assumes zero-wait APB and the register map of ppd_pkg.
 */
`timescale 1ns/1ps
`default_nettype none
module tb
	import ppd_pkg::*;
;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, fire = 1'b0, commutation_evt;
	logic [5:0]  pwm_out;
	int          n_mismatch = 0, n_tests = 0, cyc = 0, hi[6], gap;

	ppd_pwm_config dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.commutation_evt(commutation_evt), .pwm_out(pwm_out));
	ppd_commut_src src (.pclk(pclk), .fire(fire), .hold(4'h3),
		.commutation_evt(commutation_evt));

	always #5 pclk = ~pclk;

	task automatic summarize;
		$display("mismatches %0d of %0d compares", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	// Hang guard: the whole run needs well under this
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Output is registered: look once the launching edge has settled
	task automatic chk_pwm(input logic [5:0] e);
		@(negedge pclk);
		chk({26'h0, pwm_out}, {26'h0, e});
		@(posedge pclk);
	endtask : chk_pwm

	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Count high cycles per channel and cycles with pair A both low
	task automatic measure(input int n);
		hi = '{default: 0};
		gap = 0;
		repeat (n) begin
			@(negedge pclk);
			for (int i = 0; i < 6; i++)
				hi[i] += pwm_out[i];
			gap += (pwm_out[1:0] == 2'b00);
		end
		@(posedge pclk);
	endtask : measure

	task automatic t_reset;
		apb(OFS_DTMC, 1'b0, 32'h0);
		chk(rd, 32'h0000_0fff);
		apb(OFS_CFG1, 1'b0, 32'h0);
		chk(rd, 32'h0);
		apb(8'h3c, 1'b0, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(OFS_DTMC, 1'b1, 32'hffff_ffff);
		apb(OFS_DTMC, 1'b0, 32'h0);
		chk(rd, 32'h0000_0fff);
	endtask : t_reset

	task automatic t_outctl;
		apb(OFS_OUTC, 1'b1, 32'h3f);
		apb(OFS_OUTB, 1'b1, 32'h15);
		chk_pwm(6'h15);
		apb(OFS_CFG1, 1'b1, 32'h20);
		chk_pwm(6'h35);
		apb(OFS_MASK, 1'b1, 32'h01);
		chk_pwm(6'h34);
		apb(OFS_CFG1, 1'b1, 32'h60);
		apb(OFS_OUTB, 1'b1, 32'h2a);
		apb(OFS_MASK, 1'b1, 32'h02);
		repeat (8) @(posedge pclk);
		chk_pwm(6'h34);
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (10) @(posedge pclk);
		chk_pwm(6'h08);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk(rd, 32'h000a_afc8);
		// Gate driver in use: polarities back to reset values
		apb(OFS_CFG1, 1'b1, 32'h0);
		apb(OFS_OUTC, 1'b1, 32'h0);
		apb(OFS_MASK, 1'b1, 32'h0);
	endtask : t_outctl

	task automatic t_compare;
		apb(OFS_MOD, 1'b1, 32'h8);
		apb(OFS_DTMC, 1'b1, 32'h0);
		apb(OFS_CFG0, 1'b1, 32'h7);
		apb(OFS_PW0, 1'b1, 32'h1);
		apb(OFS_PW0 + 8'h04, 1'b1, 32'h5);
		apb(OFS_PW0 + 8'h08, 1'b1, 32'h3);
		apb(OFS_PW0 + 8'h0c, 1'b1, 32'h1);
		measure(16);
		measure(8);
		chk(32'(hi[0]), 32'd2);
		chk(32'(hi[1]), 32'd6);
		chk(32'(hi[3]), 32'd2);
		apb(OFS_CFG1, 1'b1, 32'h1);
		measure(16);
		chk(32'(hi[0]), 32'd12);
		apb(OFS_CFG1, 1'b1, 32'h0);
		apb(OFS_CFG0, 1'b1, 32'h0);
		measure(16);
		measure(8);
		chk(32'(hi[1]), 32'd6);
		chk(32'(hi[3]), 32'd4);
	endtask : t_compare

	task automatic t_deadtime;
		apb(OFS_PW0, 1'b1, 32'h3);
		apb(OFS_DTMC, 1'b1, 32'h2);
		measure(24);
		measure(8);
		chk(32'(gap), 32'd4);
		chk(32'(hi[0]), 32'd2);
		apb(OFS_PRSC, 1'b1, 32'h1);
		measure(40);
		measure(16);
		chk(32'(gap), 32'd8);
		chk(32'(hi[1]), 32'd4);
	endtask : t_deadtime

	task automatic t_protect;
		apb(OFS_CFG0, 1'b1, 32'h80);
		apb(OFS_CFG0, 1'b1, 32'h03);
		apb(OFS_CFG1, 1'b1, 32'h7f);
		apb(OFS_CFG0, 1'b0, 32'h0);
		chk({30'h0, rd[1:0]}, 32'h0);
		apb(OFS_CFG1, 1'b0, 32'h0);
		chk(rd, 32'h0);
	endtask : t_protect

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_outctl();
		t_compare();
		t_deadtime();
		t_protect();
		summarize();
	end
endmodule : tb
`default_nettype wire
